/* File: bsc_pkg.sv */
package bsc_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int          PC_W       = 16;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] SP_RESET   = 16'h00ff;
  localparam logic [7:0]  STAT_RESET = 8'h00;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // status flag positions
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ----------------------------------------------------------------
  // instruction word fields
  // ----------------------------------------------------------------
  localparam int OP_LO     = 12;
  localparam int SUB_LO    = 8;
  localparam int RD_LO     = 5;
  localparam int RR_LO     = 0;
  localparam int IMM_RD_LO = 8;
  localparam int IMM_LO    = 0;
  localparam int BIT_LO    = 0;
  localparam int IO_LO     = 3;
  localparam int OFS_LO    = 3;
  localparam int X_LO_IDX  = 26;
  localparam int X_HI_IDX  = 27;
  localparam int Z_LO_IDX  = 30;
  localparam int Z_HI_IDX  = 31;

  // ----------------------------------------------------------------
  // opcodes and misc sub-codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_NOP   = 4'h0;
  localparam logic [3:0] OP_CSKIP = 4'h1;
  localparam logic [3:0] OP_CMP   = 4'h2;
  localparam logic [3:0] OP_CMPB  = 4'h3;
  localparam logic [3:0] OP_CMPK  = 4'h4;
  localparam logic [3:0] OP_TEST  = 4'h5;
  localparam logic [3:0] OP_ZERO  = 4'h6;
  localparam logic [3:0] OP_ONES  = 4'h7;
  localparam logic [3:0] OP_RBLO  = 4'h8;
  localparam logic [3:0] OP_RBHI  = 4'h9;
  localparam logic [3:0] OP_IOLO  = 4'ha;
  localparam logic [3:0] OP_IOHI  = 4'hb;
  localparam logic [3:0] OP_BRHI  = 4'hc;
  localparam logic [3:0] OP_BRANCH_UNSIGNED_LT  = 4'hd;
  localparam logic [3:0] OP_MISC  = 4'he;
  localparam logic [3:0] OP_LONG  = 4'hf;
  localparam logic [3:0] SUB_PJMP = 4'h0;
  localparam logic [3:0] SUB_PCAL = 4'h1;
  localparam logic [3:0] SUB_LDX  = 4'h2;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_EXEC     = 3'b000,
    ST_BUBBLE   = 3'b001,
    ST_SKIP     = 3'b010,
    ST_LOAD     = 3'b011,
    ST_CALL_HI  = 3'b100,
    ST_CALL_JMP = 3'b101,
    ST_LONG     = 3'b110
  } bsc_state_e;

endpackage

/* File: bsc_exec_core.sv */
// Operation
// - test register sets Z N V, one cycle
// - clear register to zero, Z N V, one cycle
// - pointer jump loads PC from Z, two cycles
// - pointer call pushes return, jumps Z, three cycles
// - compare-skip-equal skips on equal, 1/2/3 cycles
// - compares subtract, set Z N V C H
// - skip when register bit is clear
// - skip when register bit is set
// - skip on io bit clear or set
// - branch when selected flag is one
// - branch when selected flag is zero
// - equal/unequal branches follow Z flag
// - carry branches follow C flag
// - unsigned ge/lt branches follow C flag
// - negative/positive branches follow N flag
// - signed ge taken when N xor V zero
// - signed less taken when N xor V one
// - half-carry branches follow H flag
// - transfer-bit branches follow T flag
// - overflow branches follow V flag
// - interrupt branches follow I flag
// - load from X, then X plus one, two cycles
`timescale 1ns/10ps
`default_nettype none
module bsc_exec_core
(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  output logic      [15:0] pmem_addr_out,
  input  wire logic [15:0] pmem_data_in,
  output logic      [15:0] dmem_addr_out,
  output logic             dmem_read_out,
  output logic             dmem_write_out,
  output logic      [7:0]  dmem_wdata_out,
  input  wire logic [7:0]  dmem_rdata_in,
  output logic      [4:0]  io_addr_out,
  input  wire logic [7:0]  io_data_in,
  input  wire logic        status_load_in,
  input  wire logic [7:0]  status_value_in,
  output logic      [7:0]  status_flags_out,
  output logic      [15:0] program_counter_out,
  output logic             fetch_out
);
  // ----------------------------------------------------------------
  // flag helpers
  // ----------------------------------------------------------------
  // logic result flags: Z, N, V only, everything else kept
  function automatic logic [7:0] logic_flags(input logic [7:0] sr, input logic [7:0] res);
    logic [7:0] f;
    f = sr;
    f[bsc_pkg::FLAG_Z] = (res == 8'h00);
    f[bsc_pkg::FLAG_N] = res[7];
    f[bsc_pkg::FLAG_V] = 1'b0;
    return f;
  endfunction
  // subtract flags; chained compare keeps Z low once a byte differed
  function automatic logic [7:0] sub_flags(input logic [7:0] sr, d, r, input logic cin, chain);
    logic [7:0] f;
    logic [7:0] res;
    f   = sr;
    res = d - r - {7'h00, cin};
    f[bsc_pkg::FLAG_Z] = (res == 8'h00) & (~chain | sr[bsc_pkg::FLAG_Z]);
    f[bsc_pkg::FLAG_N] = res[7];
    f[bsc_pkg::FLAG_V] = (d[7] & ~r[7] & ~res[7]) | (~d[7] & r[7] & res[7]);
    f[bsc_pkg::FLAG_C] = (~d[7] & r[7]) | (r[7] & res[7]) | (res[7] & ~d[7]);
    f[bsc_pkg::FLAG_H] = (~d[3] & r[3]) | (r[3] & res[3]) | (res[3] & ~d[3]);
    return f;
  endfunction
  // the sign slot is always read as N xor V so it can never go stale
  function automatic logic flag_of(input logic [7:0] sr, input logic [2:0] sel);
    return (sel == 3'(bsc_pkg::FLAG_S)) ? sr[bsc_pkg::FLAG_N] ^ sr[bsc_pkg::FLAG_V]
                                        : sr[sel];
  endfunction
  // the only two-word form is the long jump
  function automatic logic is_two_word(input logic [15:0] w);
    return w[15:bsc_pkg::OP_LO] == bsc_pkg::OP_LONG;
  endfunction

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  logic [7:0]          regs [0:31];
  logic [15:0]         pc;
  logic [15:0]         sp;
  logic [7:0]          flags;
  bsc_pkg::bsc_state_e state;
  logic [4:0]          load_dst;
  logic [15:0]         next_pc;
  logic [15:0]         next_sp;
  logic [7:0]          next_flags;
  bsc_pkg::bsc_state_e next_state;
  logic [4:0]          next_load_dst;
  logic                reg_we;
  logic [4:0]          reg_wa;
  logic [7:0]          reg_wd;
  logic                x_inc;
  logic [15:0]         next_dm_addr;
  logic                next_dm_rd;
  logic                next_dm_wr;
  logic [7:0]          next_dm_wd;
  logic [3:0]          op;
  logic [4:0]          rd;
  logic [4:0]          rr;
  logic [4:0]          rdk;
  logic [7:0]          imm;
  logic [2:0]          bsel;
  logic [15:0]         ofs;
  logic [7:0]          val_d;
  logic [7:0]          val_r;
  logic [7:0]          val_k;
  logic [15:0]         ptr_x;
  logic [15:0]         ptr_z;
  logic [15:0]         pc_seq;
  assign op     = pmem_data_in[15:bsc_pkg::OP_LO];
  assign rd     = pmem_data_in[bsc_pkg::RD_LO +: 5];
  assign rr     = pmem_data_in[bsc_pkg::RR_LO +: 5];
  assign rdk    = {1'b1, pmem_data_in[bsc_pkg::IMM_RD_LO +: 4]}; // upper half only
  assign imm    = pmem_data_in[bsc_pkg::IMM_LO +: 8];
  assign bsel   = pmem_data_in[bsc_pkg::BIT_LO +: 3];
  assign ofs    = {{9{pmem_data_in[bsc_pkg::OFS_LO + 6]}},
                   pmem_data_in[bsc_pkg::OFS_LO +: 7]};
  assign val_d  = regs[rd];
  assign val_r  = regs[rr];
  assign val_k  = regs[rdk];
  assign ptr_x  = {regs[bsc_pkg::X_HI_IDX], regs[bsc_pkg::X_LO_IDX]};
  assign ptr_z  = {regs[bsc_pkg::Z_HI_IDX], regs[bsc_pkg::Z_LO_IDX]};
  assign pc_seq = pc + 16'h0001;
  // io address is taken straight from the word so the bit test fits in one cycle
  assign io_addr_out         = pmem_data_in[bsc_pkg::IO_LO +: 5];
  assign pmem_addr_out       = pc;
  assign program_counter_out = pc;
  assign status_flags_out    = flags;
  assign fetch_out           = (state == bsc_pkg::ST_EXEC);

  // ----------------------------------------------------------------
  // execute and sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_pc       = pc;
    next_sp       = sp;
    next_flags    = flags;
    next_state    = state;
    next_load_dst = load_dst;
    reg_we        = 1'b0;
    reg_wa        = rd;
    reg_wd        = 8'h00;
    x_inc         = 1'b0;
    next_dm_addr  = dmem_addr_out;
    next_dm_rd    = 1'b0;
    next_dm_wr    = 1'b0;
    next_dm_wd    = dmem_wdata_out;
    unique case (state)
      bsc_pkg::ST_EXEC:
      begin
        next_pc = pc_seq;
        unique case (op)
          bsc_pkg::OP_NOP: ;
          bsc_pkg::OP_CSKIP:
            if (val_d == val_r) next_state = bsc_pkg::ST_SKIP;
          bsc_pkg::OP_CMP:
            next_flags = sub_flags(flags, val_d, val_r, 1'b0, 1'b0);
          bsc_pkg::OP_CMPB:
            next_flags = sub_flags(flags, val_d, val_r, flags[bsc_pkg::FLAG_C], 1'b1);
          bsc_pkg::OP_CMPK:
            next_flags = sub_flags(flags, val_k, imm, 1'b0, 1'b0);
          bsc_pkg::OP_TEST:
            next_flags = logic_flags(flags, val_d & val_d);
          bsc_pkg::OP_ZERO:
          begin
            reg_we     = 1'b1;
            reg_wd     = val_d ^ val_d;
            next_flags = logic_flags(flags, val_d ^ val_d);
          end
          bsc_pkg::OP_ONES:
          begin
            reg_we = 1'b1;
            reg_wa = rdk;
            reg_wd = 8'hff;
          end
          bsc_pkg::OP_RBLO:
            if (!val_d[bsel]) next_state = bsc_pkg::ST_SKIP;
          bsc_pkg::OP_RBHI:
            if (val_d[bsel]) next_state = bsc_pkg::ST_SKIP;
          bsc_pkg::OP_IOLO:
            if (!io_data_in[bsel]) next_state = bsc_pkg::ST_SKIP;
          bsc_pkg::OP_IOHI:
            if (io_data_in[bsel]) next_state = bsc_pkg::ST_SKIP;
          bsc_pkg::OP_BRHI, bsc_pkg::OP_BRANCH_UNSIGNED_LT:
            // named branches are these two with a fixed select value
            if (flag_of(flags, bsel) == (op == bsc_pkg::OP_BRHI))
            begin
              next_pc    = pc_seq + ofs;
              next_state = bsc_pkg::ST_BUBBLE; // z c n h t v i
            end
          bsc_pkg::OP_MISC:
            case (pmem_data_in[bsc_pkg::SUB_LO +: 4])
              bsc_pkg::SUB_PJMP:
              begin
                next_pc    = ptr_z;
                next_state = bsc_pkg::ST_BUBBLE;
              end
              bsc_pkg::SUB_PCAL:
              begin
                // low byte of the return address first, stack grows down
                next_dm_addr = sp;
                next_dm_wd   = pc_seq[7:0];
                next_dm_wr   = 1'b1;
                next_sp      = sp - 16'h0001;
                next_state   = bsc_pkg::ST_CALL_HI;
              end
              bsc_pkg::SUB_LDX:
              begin
                next_dm_addr  = ptr_x;
                next_dm_rd    = 1'b1;
                next_load_dst = rr;
                next_state    = bsc_pkg::ST_LOAD;
              end
              default: ;
            endcase
          bsc_pkg::OP_LONG:
            next_state = bsc_pkg::ST_LONG;
        endcase
      end
      bsc_pkg::ST_SKIP:
      begin
        // the word now on the bus is the one being skipped
        next_pc    = is_two_word(pmem_data_in) ? pc + 16'h0002 : pc_seq;
        next_state = is_two_word(pmem_data_in) ? bsc_pkg::ST_BUBBLE : bsc_pkg::ST_EXEC;
      end
      bsc_pkg::ST_BUBBLE:
        next_state = bsc_pkg::ST_EXEC;
      bsc_pkg::ST_LOAD:
      begin
        reg_we     = 1'b1;
        reg_wa     = load_dst;
        reg_wd     = dmem_rdata_in;
        x_inc      = 1'b1;
        next_state = bsc_pkg::ST_EXEC;
      end
      bsc_pkg::ST_CALL_HI:
      begin
        next_dm_addr = sp;
        next_dm_wd   = pc[15:8];
        next_dm_wr   = 1'b1;
        next_sp      = sp - 16'h0001;
        next_state   = bsc_pkg::ST_CALL_JMP;
      end
      bsc_pkg::ST_CALL_JMP:
      begin
        next_pc    = ptr_z;
        next_state = bsc_pkg::ST_EXEC;
      end
      bsc_pkg::ST_LONG:
      begin
        next_pc    = pmem_data_in;
        next_state = bsc_pkg::ST_EXEC;
      end
      default:
        next_state = bsc_pkg::ST_EXEC;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  // program counter, stack pointer, state
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pc       <= bsc_pkg::PC_RESET;
      sp       <= bsc_pkg::SP_RESET;
      state    <= bsc_pkg::ST_EXEC;
      load_dst <= 5'h00;
    end
    else
    begin
      pc       <= next_pc;
      sp       <= next_sp;
      state    <= next_state;
      load_dst <= next_load_dst;
    end
  end
  // status flags; a direct load from outside wins over instruction updates
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      flags <= bsc_pkg::STAT_RESET;
    else if (status_load_in)
      flags <= status_value_in;
    else
      flags <= next_flags;
  end
  // data memory strobes, registered so the memory sees clean levels
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dmem_addr_out  <= bsc_pkg::ADDR_RESET;
      dmem_read_out  <= 1'b0;
      dmem_write_out <= 1'b0;
      dmem_wdata_out <= 8'h00;
    end
    else
    begin
      dmem_addr_out  <= next_dm_addr;
      dmem_read_out  <= next_dm_rd;
      dmem_write_out <= next_dm_wr;
      dmem_wdata_out <= next_dm_wd;
    end
  end

  // ----------------------------------------------------------------
  // working registers
  // ----------------------------------------------------------------
  // pointer increment comes last so it wins if the load targets X itself
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < 32; i++)
        regs[i] <= bsc_pkg::REG_RESET;
    end
    else
    begin
      if (reg_we)
        regs[reg_wa] <= reg_wd;
      if (x_inc)
        {regs[bsc_pkg::X_HI_IDX], regs[bsc_pkg::X_LO_IDX]} <= ptr_x + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* File: bsc_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------
// program, data and io storage
// ---------------------------------
module bsc_mem_model
(
  input  wire logic        clock_in,
  input  wire logic [15:0] pmem_addr_in,
  output logic      [15:0] pmem_data_out,
  input  wire logic [15:0] dmem_addr_in,
  input  wire logic        dmem_read_in,
  input  wire logic        dmem_write_in,
  input  wire logic [7:0]  dmem_wdata_in,
  output logic      [7:0]  dmem_rdata_out,
  input  wire logic [4:0]  io_addr_in,
  output logic      [7:0]  io_data_out
);
  logic [15:0] prog [0:255];
  logic [7:0]  data [0:255];
  logic [7:0]  io   [0:31];
  // combinational reads; unselected data bus shows the inverse, not a held value
  assign pmem_data_out  = prog[pmem_addr_in[7:0]];
  assign dmem_rdata_out = dmem_read_in ? data[dmem_addr_in[7:0]] : ~data[dmem_addr_in[7:0]];
  assign io_data_out    = io[io_addr_in];
  // write lands on the edge closing the strobe cycle; bench presets the array too
  always @(posedge clock_in)
  begin
    if (dmem_write_in)
      data[dmem_addr_in[7:0]] <= dmem_wdata_in;
  end
endmodule
`default_nettype wire

/* File: bsc_exec_core_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------
// port-level checks of the core
// ---------------------------------
module bsc_exec_core_properties
(
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] pmem_addr_out,
  input wire logic [15:0] pmem_data_in,
  input wire logic [15:0] dmem_addr_out,
  input wire logic        dmem_read_out,
  input wire logic        dmem_write_out,
  input wire logic [7:0]  dmem_wdata_out,
  input wire logic [7:0]  dmem_rdata_in,
  input wire logic [4:0]  io_addr_out,
  input wire logic [7:0]  io_data_in,
  input wire logic        status_load_in,
  input wire logic [7:0]  status_value_in,
  input wire logic [7:0]  status_flags_out,
  input wire logic [15:0] program_counter_out,
  input wire logic        fetch_out
);
  logic [3:0]  op;
  logic [15:0] br_target;
  logic        flag_pick;
  logic        is_br;
  logic        is_misc;
  // decode of the word being fetched; signed test reads n xor v
  assign op        = pmem_data_in[15:12];
  assign is_br     = fetch_out && (op == bsc_pkg::OP_BRHI || op == bsc_pkg::OP_BRANCH_UNSIGNED_LT);
  assign is_misc   = fetch_out && op == bsc_pkg::OP_MISC;
  assign br_target = program_counter_out + 16'h1 + {{9{pmem_data_in[9]}}, pmem_data_in[9:3]};
  assign flag_pick = (pmem_data_in[2:0] == 3'h4) ?
                     (status_flags_out[bsc_pkg::FLAG_N] ^ status_flags_out[bsc_pkg::FLAG_V]) :
                     status_flags_out[pmem_data_in[2:0]];

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_io_skip;
    fetch_out && (op == bsc_pkg::OP_IOLO || op == bsc_pkg::OP_IOHI)
    && (io_data_in[pmem_data_in[2:0]] == (op == bsc_pkg::OP_IOHI));
  endsequence
  sequence s_call_push;
    !fetch_out && dmem_write_out && dmem_wdata_out == program_counter_out[7:0]
    ##1 !fetch_out && dmem_write_out && dmem_wdata_out == program_counter_out[15:8]
    && dmem_addr_out == $past(dmem_addr_out) - 16'h1;
  endsequence

  a_branch_taken : assert property (
    is_br && (flag_pick == (op == bsc_pkg::OP_BRHI))
    |=> !fetch_out && program_counter_out == $past(br_target) ##1 fetch_out)
    else $error("taken branch target or timing wrong");
  a_branch_missed : assert property (
    is_br && (flag_pick != (op == bsc_pkg::OP_BRHI))
    |=> fetch_out && program_counter_out == $past(program_counter_out) + 16'h1)
    else $error("untaken branch did not fall through in one cycle");
  a_branch_flags : assert property (
    is_br && !status_load_in |=> $stable(status_flags_out))
    else $error("branch altered flags");
  a_jump_cycles : assert property (
    is_misc && pmem_data_in[11:8] == bsc_pkg::SUB_PJMP |=> !fetch_out ##1 fetch_out)
    else $error("pointer jump not two cycles");
  a_call_push : assert property (
    is_misc && pmem_data_in[11:8] == bsc_pkg::SUB_PCAL |=> s_call_push ##1 fetch_out)
    else $error("pointer call push or timing wrong");
  a_load_read : assert property (
    is_misc && pmem_data_in[11:8] == bsc_pkg::SUB_LDX
    |=> dmem_read_out && !fetch_out ##1 fetch_out && !dmem_read_out)
    else $error("indirect load strobe or timing wrong");
  a_test_flags : assert property (
    fetch_out && op == bsc_pkg::OP_TEST && !status_load_in
    |=> !status_flags_out[bsc_pkg::FLAG_V]
    && (status_flags_out & 8'hf1) == ($past(status_flags_out) & 8'hf1))
    else $error("test touched wrong flags");
  a_clear_flags : assert property (
    fetch_out && op == bsc_pkg::OP_ZERO && !status_load_in
    |=> status_flags_out[3:1] == 3'b001
    && (status_flags_out & 8'hf1) == ($past(status_flags_out) & 8'hf1))
    else $error("clear gave wrong flags");
  a_io_skip_short : assert property (
    s_io_skip ##1 (!fetch_out && op != bsc_pkg::OP_LONG)
    |=> fetch_out && program_counter_out == $past(program_counter_out, 2) + 16'h2)
    else $error("skip over one word wrong");
  a_io_skip_long : assert property (
    s_io_skip ##1 (!fetch_out && op == bsc_pkg::OP_LONG)
    |=> !fetch_out ##1 fetch_out && program_counter_out == $past(program_counter_out, 3) + 16'h3)
    else $error("skip over two words wrong");
endmodule

bind bsc_exec_core bsc_exec_core_properties u_props
(
  .clock_in, .rst_n_in, .pmem_addr_out, .pmem_data_in, .dmem_addr_out, .dmem_read_out,
  .dmem_write_out, .dmem_wdata_out, .dmem_rdata_in, .io_addr_out, .io_data_in,
  .status_load_in, .status_value_in, .status_flags_out, .program_counter_out, .fetch_out
);
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------
// self-checking bench of the core
// ---------------------------------
module tb_top;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        status_load_in = 1'b0;
  logic [7:0]  status_value_in = 8'h00;
  logic [15:0] pmem_addr, pmem_data, dmem_addr, pc;
  logic [7:0]  dmem_wdata, dmem_rdata, io_data, flags;
  logic [4:0]  io_addr;
  logic        dmem_read, dmem_write, fetch;
  int          fail_count = 0;
  int          checked = 0;

  always #20 clock_in = ~clock_in;

  bsc_exec_core DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .pmem_addr_out(pmem_addr),
    .pmem_data_in(pmem_data), .dmem_addr_out(dmem_addr), .dmem_read_out(dmem_read),
    .dmem_write_out(dmem_write), .dmem_wdata_out(dmem_wdata), .dmem_rdata_in(dmem_rdata),
    .io_addr_out(io_addr), .io_data_in(io_data), .status_load_in(status_load_in),
    .status_value_in(status_value_in), .status_flags_out(flags),
    .program_counter_out(pc), .fetch_out(fetch));
  bsc_mem_model mem (.clock_in(clock_in), .pmem_addr_in(pmem_addr), .pmem_data_out(pmem_data),
    .dmem_addr_in(dmem_addr), .dmem_read_in(dmem_read), .dmem_write_in(dmem_write),
    .dmem_wdata_in(dmem_wdata), .dmem_rdata_out(dmem_rdata), .io_addr_in(io_addr),
    .io_data_out(io_data));

  // one comparison, counted
  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reset for 20 cycles with a fresh program; returns just before the first edge
  task automatic restart(input logic [15:0] w0, w1, w2, w3);
    rst_n_in = 1'b0;
    for (int i = 0; i < 256; i++)
      mem.prog[i] = 16'h0000;
    mem.prog[0] = w0;
    mem.prog[1] = w1;
    mem.prog[2] = w2;
    mem.prog[3] = w3;
    repeat (20) @(negedge clock_in);
    rst_n_in = 1'b1;
  endtask

  // flag results of compare, test and clear, one per cycle
  task automatic test_flags;
    logic [15:0] prg [11] = '{16'h7000, 16'h4001, 16'h5200, 16'h6200, 16'h4001, 16'h5200,
                              16'h4080, 16'h5200, 16'h3210, 16'h2210, 16'h3210};
    logic [7:0]  exf [11] = '{8'h00, 8'h04, 8'h04, 8'h02, 8'h25, 8'h23, 8'h0d, 8'h03, 8'h25,
                              8'h02, 8'h02};
    restart(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    for (int i = 0; i < 11; i++)
      mem.prog[i] = prg[i];
    for (int i = 0; i < 11; i++)
    begin
      @(negedge clock_in);
      cmp_val("flags", {8'h00, exf[i]}, {8'h00, flags});
      cmp_val("fetch", 16'h0001, {15'h0000, fetch});
    end
  endtask

  // every flag select, both senses, several flag images, both offset signs
  task automatic test_branches;
    logic [7:0] img [4] = '{8'h00, 8'hff, 8'h04, 8'h08};
    logic [6:0] ofs;
    logic       hit;
    for (int i = 0; i < 4; i++)
      for (int s = 0; s < 8; s++)
        for (int o = 0; o < 2; o++)
        begin
          ofs = i[0] ? 7'h7d : 7'h05;
          hit = (s == 4) ? (img[i][2] ^ img[i][3]) : img[i][s];
          hit = (o == 0) ? hit : !hit;
          restart(16'h0000, {(o == 0) ? bsc_pkg::OP_BRHI : bsc_pkg::OP_BRANCH_UNSIGNED_LT, 2'b00, ofs, s[2:0]},
                  16'h0000, 16'h0000);
          status_value_in = img[i];
          status_load_in  = 1'b1;
          @(negedge clock_in);
          status_load_in = 1'b0;
          @(negedge clock_in);
          cmp_val("pc", hit ? 16'h2 + {{9{ofs[6]}}, ofs} : 16'h2, pc);
          cmp_val("fetch", {15'h0000, !hit}, {15'h0000, fetch});
          cmp_val("flags", {8'h00, img[i]}, {8'h00, flags});
        end
  endtask

  // skips, pointer jump, call and load: cycles to next fetch and landing address
  task automatic test_skips;
    logic [15:0] tab [12][6] = '{
      '{16'ha028, 0, 0, 0, 2, 2}, '{16'ha029, 16'hf000, 16'h0040, 0, 1, 1},
      '{16'hb029, 16'hf000, 16'h0040, 0, 3, 3}, '{16'hb028, 0, 0, 0, 1, 1},
      '{16'h8000, 0, 0, 0, 2, 2}, '{16'h9000, 16'hf000, 0, 0, 1, 1},
      '{16'h1001, 16'hf000, 0, 0, 3, 3}, '{16'h7000, 16'h1211, 0, 1, 1, 2},
      '{16'h7000, 16'h9203, 0, 1, 2, 3}, '{16'he000, 0, 0, 0, 2, 0},
      '{16'he200, 0, 0, 0, 2, 1}, '{16'he100, 0, 0, 0, 3, 0}};
    int n;
    for (int i = 0; i < 12; i++)
    begin
      restart(tab[i][0], tab[i][1], tab[i][2], 16'h0000);
      repeat (tab[i][3] + 1) @(negedge clock_in);
      n = 1;
      while (fetch !== 1'b1 && n < 8)
      begin
        @(negedge clock_in);
        n++;
      end
      cmp_val("cycles", tab[i][4], n[15:0]);
      cmp_val("pc", tab[i][5], pc);
      cmp_val("fetch addr", tab[i][5], pmem_addr);
      cmp_val("flags", 16'h0000, {8'h00, flags});
    end
    cmp_val("push low", 16'h0001, {8'h00, mem.data[255]});
    cmp_val("push high", 16'h0000, {8'h00, mem.data[254]});
  endtask

  // two loads through x, each judged by a following test
  task automatic test_load;
    restart(16'he210, 16'h5200, 16'he210, 16'h5200);
    repeat (3) @(negedge clock_in);
    cmp_val("flags", 16'h0004, {8'h00, flags});
    repeat (3) @(negedge clock_in);
    cmp_val("flags", 16'h0002, {8'h00, flags});
  endtask

  initial
  begin
    for (int i = 0; i < 32; i++)
      mem.io[i] = 8'h00;
    mem.io[5]     = 8'h0a;
    mem.data[0]   = 8'h80;
    mem.data[1]   = 8'h00;
    mem.data[254] = 8'h55;
    mem.data[255] = 8'h55;
    test_flags();
    test_branches();
    test_skips();
    test_load();
    stop_test();
  end

  // hang guard, several times the expected run length
  initial
  begin
    #400000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
